// [logic/dac_update_map.svh]
/*
 * Constants of the converter update path: channel count, code width, field positions.
 * Assumes it is included by bare name from the package and the design module.
 */
`ifndef DAC_UPDATE_MAP_SVH
`define DAC_UPDATE_MAP_SVH

`define NUM_CH            16
`define NUM_PAIRS         8
`define CHAN_W            4
`define CODE_W            16
`define RES_DEFAULT       16
`define RANGE_W           3
`define RANGE_BIPOLAR_BIT 2
`define CLEAR_ZERO        16'h0000

`endif

// [logic/dac_update_pkg.sv]
/*
 * Types shared by the update path: range codes, frame kinds and the state records
 * of the core and link domains.
 * Assumes dac_update_map.svh is on the include path.
 */
`default_nettype none
`include "dac_update_map.svh"

package dac_update_pkg;

    typedef logic [`CODE_W-1:0] code_t;

    // ----------------------------------------------------------------
    // output spans; the top bit marks a bipolar span
    // ----------------------------------------------------------------
    typedef enum logic [`RANGE_W-1:0] {
        RANGE_U5, RANGE_U10, RANGE_U20, RANGE_U40,
        RANGE_B2P5, RANGE_B5, RANGE_B10, RANGE_B20
    } range_e;

    typedef enum logic [1:0] {
        KIND_DATA, KIND_ALT, KIND_BCAST, KIND_TRIGGER
    } frame_e;

    typedef struct packed {
        logic                    clearS1;
        logic                    clearS2;
        logic                    ldS1;
        logic                    ldS2;
        logic                    ldPrev;
        logic                    reqS1;
        logic                    reqS2;
        logic                    reqSeen;
        logic [`NUM_CH-1:0]      ampOn;
        logic [`NUM_CH-1:0]      updated;
        code_t [`NUM_CH-1:0]     bufCode;
        code_t [`NUM_CH-1:0]     activeCode;
        code_t [`NUM_CH-1:0]     altCode;
        code_t [`NUM_CH-1:0]     outCode;
    } core_s;

    typedef struct packed {
        logic                    rstS1;
        logic                    rstS2;
        logic                    req;
        logic                    ackS1;
        logic                    ackS2;
        frame_e                  kind;
        logic [`CHAN_W-1:0]      chan;
        code_t                   data;
    } link_s;

endpackage : dac_update_pkg

`default_nettype wire

// [logic/dac_update_control.sv]
/*
 * Buffer/active register update path of a 16-channel converter, with the
 * link-side frame capture and its crossing into the core clock.
 * Assumes the serial deframer delivers one decoded frame per frameEnd pulse on
 * linkClk, and that clear and load pins arrive asynchronously.
 */
`default_nettype none
`include "dac_update_map.svh"

module dac_update_control #(
    parameter int RES = `RES_DEFAULT
) (
    input  wire logic                                   clk,
    input  wire logic                                   rst_n,
    input  wire logic                                   linkClk,
    input  wire logic                                   frameEnd,
    input  wire dac_update_pkg::frame_e                 frameKind,
    input  wire logic [`CHAN_W-1:0]                     frameChan,
    input  wire dac_update_pkg::code_t                  frameData,
    output logic                                        frameReady,
    input  wire logic                                   loadTriggerPin_n,
    input  wire logic                                   clearOutputsPin_n,
    input  wire logic [`NUM_CH-1:0]                     syncEnable,
    input  wire logic [`NUM_CH-1:0]                     channelBroadcastJoin,
    input  wire logic [`NUM_PAIRS-1:0]                  diffPair,
    input  wire dac_update_pkg::range_e [`NUM_CH-1:0]   rangeSel,
    input  wire logic [`NUM_CH-1:0]                     toggleEnable,
    input  wire logic [`NUM_CH-1:0]                     toggleSelect,
    input  wire logic [`NUM_CH-1:0]                     chanPowerUp,
    output dac_update_pkg::code_t [`NUM_CH-1:0]         dacCode,
    output logic [`NUM_CH-1:0]                          outputUpdated,
    output logic [`NUM_CH-1:0]                          ampPowered
);
    import dac_update_pkg::*;

    // ----------------------------------------------------------------
    // codes and clear values
    // ----------------------------------------------------------------
    localparam code_t CODE_MASK = code_t'((32'h1 << RES) - 1);
    localparam code_t MIDSCALE  = code_t'(32'h1 << (RES - 1));

    // pins idle high after reset so release does not fire clear or load
    localparam core_s CORE_RST = '{clearS1: 1'b1, clearS2: 1'b1, ldS1: 1'b1, ldS2: 1'b1,
                                   ldPrev: 1'b1, default: '0};

    core_s s;
    core_s next_s;
    link_s l;
    link_s next_l;

    logic                   wrEvt;
    logic                   loadEvt;
    logic                   anyDiff;
    code_t                  wrCode;
    code_t [`NUM_CH-1:0]    clearCode;

    always_comb begin
        for (int g = 0; g < `NUM_CH; g++) begin
            // span bit comes from this channel's own setting, pair flag from the diffPair bit it shares with its pair partner
            if (!rangeSel[g][`RANGE_BIPOLAR_BIT] && !diffPair[g / 2]) begin
                clearCode[g] = `CLEAR_ZERO;
            end else begin
                clearCode[g] = MIDSCALE;
            end
        end
    end

    assign anyDiff = |diffPair;
    assign wrEvt   = s.reqS2 != s.reqSeen;
    assign wrCode  = l.data & CODE_MASK;
    // trigger frames carry no data and load the sync channels like a load pin fall
    assign loadEvt = (s.ldPrev && !s.ldS2)
                   || (wrEvt && l.kind == KIND_TRIGGER);

    // ----------------------------------------------------------------
    // core domain
    // ----------------------------------------------------------------
    always_comb begin
        next_s         = s;
        next_s.clearS1 = clearOutputsPin_n;
        next_s.clearS2 = s.clearS1;
        next_s.ldS1    = loadTriggerPin_n;
        next_s.ldS2    = s.ldS1;
        next_s.ldPrev  = s.ldS2;
        next_s.reqS1   = l.req;
        next_s.reqS2   = s.reqS1;
        next_s.reqSeen = s.reqS2;
        next_s.ampOn   = chanPowerUp;
        if (wrEvt) begin
            case (l.kind)
                KIND_DATA: begin
                    next_s.bufCode[l.chan] = wrCode;
                    if (!syncEnable[l.chan]) begin
                        next_s.activeCode[l.chan] = wrCode;
                    end
                end
                KIND_ALT: begin
                    next_s.altCode[l.chan] = wrCode;
                end
                KIND_BCAST: begin
                    // a single differential pair voids the whole broadcast
                    if (!anyDiff) begin
                        for (int g = 0; g < `NUM_CH; g++) begin
                            if (channelBroadcastJoin[g]) begin
                                next_s.bufCode[g] = wrCode;
                                if (!syncEnable[g]) begin
                                    next_s.activeCode[g] = wrCode;
                                end
                            end
                        end
                    end
                end
                default: begin
                end
            endcase
        end
        if (loadEvt) begin
            for (int g = 0; g < `NUM_CH; g++) begin
                if (syncEnable[g]) begin
                    next_s.activeCode[g] = next_s.bufCode[g];
                end
            end
        end
        // clear applied last so it wins over any write or trigger
        if (!s.clearS2) begin
            for (int g = 0; g < `NUM_CH; g++) begin
                next_s.bufCode[g]    = clearCode[g];
                next_s.activeCode[g] = clearCode[g];
                next_s.altCode[g]    = clearCode[g];
            end
        end
        for (int g = 0; g < `NUM_CH; g++) begin
            next_s.outCode[g] = (toggleEnable[g] && toggleSelect[g]) ? s.altCode[g]
                                                                    : s.activeCode[g];
            next_s.updated[g] = next_s.outCode[g] != s.outCode[g];
        end
        if (!rst_n) begin
            next_s = CORE_RST;
        end
    end

    always_ff @(posedge clk) begin
        s <= next_s;
    end

    assign dacCode       = s.outCode;
    assign outputUpdated = s.updated;
    // amplifier off means the pin is clamped to ground
    assign ampPowered    = s.ampOn;

    // ----------------------------------------------------------------
    // link domain
    // ----------------------------------------------------------------
    // fields stay frozen until the core acknowledges, so the core may read them
    assign frameReady = l.rstS2 && (l.req == l.ackS2);

    always_comb begin
        next_l       = l;
        next_l.rstS1 = rst_n;
        next_l.rstS2 = l.rstS1;
        next_l.ackS1 = s.reqSeen;
        next_l.ackS2 = l.ackS1;
        if (frameEnd && frameReady) begin
            next_l.req  = ~l.req;
            next_l.kind = frameKind;
            next_l.chan = frameChan;
            next_l.data = frameData;
        end
        if (!l.rstS2) begin
            next_l       = '0;
            next_l.rstS1 = rst_n;
            next_l.rstS2 = l.rstS1;
        end
    end

    always_ff @(posedge linkClk) begin
        l <= next_l;
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_dataWrite;
        wrEvt && l.kind == KIND_DATA && s.clearS2;
    endsequence

    sequence s_bcastWrite;
        wrEvt && l.kind == KIND_BCAST && s.clearS2 && !loadEvt;
    endsequence

    sequence s_pinFall;
        s.ldS2 ##1 !s.ldS2;
    endsequence

    a_buffer_write: assert property (s_dataWrite |=> s.bufCode[$past(l.chan)] == $past(wrCode))
        else $error("data write did not reach the buffer");

    a_async_copy: assert property ((s_dataWrite ##0 !syncEnable[l.chan]) |=>
        s.activeCode[$past(l.chan)] == $past(wrCode))
        else $error("async write did not reach the active register");

    a_sync_hold: assert property ((s_dataWrite ##0 syncEnable[l.chan] && !loadEvt) |=>
        s.activeCode[$past(l.chan)] == $past(s.activeCode[l.chan]))
        else $error("sync channel active changed without a trigger");

    a_bcast_void: assert property ((s_bcastWrite ##0 anyDiff) |=> $stable(s.bufCode))
        else $error("broadcast changed a buffer while a pair is differential");

    a_reset_state: assert property (@(posedge clk) disable iff (1'b0)
        !rst_n |=> s.activeCode == '0 && s.ampOn == '0 ##1 s.outCode == '0)
        else $error("reset did not zero codes and power down amplifiers");

    a_pin_trigger: assert property (s_pinFall |-> loadEvt)
        else $error("synchronised load pin fall made no trigger");

    a_clear_wins: assert property ((loadEvt && !s.clearS2) |=>
        s.activeCode == $past(clearCode))
        else $error("load trigger overrode a simultaneous clear");

    for (genvar g = 0; g < `NUM_CH; g++) begin : g_chk
        a_bcast_join: assert property ((s_bcastWrite ##0 !anyDiff && channelBroadcastJoin[g]) |=>
            s.bufCode[g] == $past(wrCode))
            else $error("joined channel missed a broadcast");

        a_load_sync: assert property ((loadEvt && s.clearS2 && syncEnable[g] && !wrEvt) |=>
            s.activeCode[g] == $past(s.bufCode[g]))
            else $error("trigger did not load a sync channel");

        a_clear_code: assert property (!s.clearS2 |=> s.activeCode[g] == $past(clearCode[g])
            && s.bufCode[g] == $past(clearCode[g]) && s.altCode[g] == $past(clearCode[g]))
            else $error("clear left a register off its clear code");

        a_out_follow: assert property (!toggleEnable[g] ##1 !toggleEnable[g] |->
            s.outCode[g] == $past(s.activeCode[g]))
            else $error("output code does not follow the active register");

        a_trigger_load: assert property ((wrEvt && l.kind == KIND_TRIGGER && s.clearS2
            && syncEnable[g]) |=> s.activeCode[g] == $past(s.bufCode[g]))
            else $error("trigger frame did not load a sync channel");

        a_bcast_async: assert property ((s_bcastWrite ##0 !anyDiff
            && channelBroadcastJoin[g] && !syncEnable[g]) |=> s.activeCode[g] == $past(wrCode))
            else $error("async joined channel did not apply a broadcast");

        a_bcast_sync_hold: assert property ((s_bcastWrite ##0 syncEnable[g]) |=>
            s.activeCode[g] == $past(s.activeCode[g]))
            else $error("sync channel applied a broadcast without a trigger");

        a_bcast_skip: assert property ((s_bcastWrite ##0 !channelBroadcastJoin[g]) |=>
            s.bufCode[g] == $past(s.bufCode[g]))
            else $error("channel outside the broadcast group took a broadcast");

        a_power_keep: assert property ((!chanPowerUp[g] && s.ampOn[g] && !wrEvt
            && !loadEvt && s.clearS2) |=> s.bufCode[g] == $past(s.bufCode[g])
            && s.activeCode[g] == $past(s.activeCode[g]))
            else $error("powering down changed the codes of a channel");

        a_alt_follow: assert property ((toggleEnable[g] && toggleSelect[g]) |=>
            s.outCode[g] == $past(s.altCode[g]))
            else $error("output code does not follow the alternate register");

        a_code_range: assert property (((s.bufCode[g] | s.activeCode[g] | s.altCode[g])
            & ~CODE_MASK) == '0)
            else $error("a stored code exceeds the converter resolution");

        a_clear_zero: assert property ((!s.clearS2 && !rangeSel[g][`RANGE_BIPOLAR_BIT]
            && !diffPair[g / 2]) |=> s.activeCode[g] == '0 && s.altCode[g] == '0)
            else $error("single-ended unipolar channel did not clear to zero");

        a_clear_mid: assert property ((!s.clearS2 && (rangeSel[g][`RANGE_BIPOLAR_BIT]
            || diffPair[g / 2])) |=> s.activeCode[g] == MIDSCALE && s.altCode[g] == MIDSCALE)
            else $error("bipolar or differential channel did not clear to midscale");
    end

endmodule : dac_update_control

`default_nettype wire

// [tb/host_link_model.sv]
/*
 * Host side of the link: hands one decoded frame at a time to the block.
 * Assumes linkClk runs free and frameReady settles by the falling edge.
 */
`default_nettype none
`include "dac_update_map.svh"

module host_link_model (
    input  wire logic              linkClk,
    input  wire logic              frameReady,
    output logic                   frameEnd,
    output dac_update_pkg::frame_e frameKind,
    output logic [`CHAN_W-1:0]     frameChan,
    output dac_update_pkg::code_t  frameData
);
    timeunit 1ns;
    timeprecision 1ps;
    import dac_update_pkg::*;

    initial begin
        frameEnd = 1'b0;
        frameKind = KIND_DATA;
        frameChan = 4'h0;
        frameData = 16'h0000;
    end

    // ------------------------------------------------------------
    // one frame; fields turn to junk once released
    // ------------------------------------------------------------
    task automatic send(input frame_e k, input logic [3:0] c, input code_t d, output bit ok);
        int n = 0;
        do begin
            @(negedge linkClk);
            n++;
        end while (frameReady !== 1'b1 && n < 200);
        @(posedge linkClk);
        frameEnd <= 1'b1;
        frameKind <= k;
        frameChan <= c;
        frameData <= d;
        @(posedge linkClk);
        frameEnd <= 1'b0;
        frameKind <= frame_e'(~k);
        frameChan <= ~c;
        frameData <= ~d;
        ok = (n < 200);
    endtask : send
endmodule : host_link_model

`default_nettype wire

// [tb/multichannel_dac_update_control_tb.sv]
/*
 * Self-checking bench of the converter update path, frames from host_link_model.
 * Assumes the design package and map header are compiled first.
 */
`default_nettype none

module multichannel_dac_update_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dac_update_pkg::*;

    localparam code_t MID = 16'h0001 << 15;
    logic clk = 1'b0;
    logic linkClk = 1'b0;
    logic rst_n, frameEnd, frameReady, loadTriggerPin_n, clearOutputsPin_n;
    frame_e frameKind;
    logic [3:0] frameChan;
    code_t frameData;
    logic [15:0] syncEnable, channelBroadcastJoin, toggleEnable, toggleSelect;
    logic [15:0] chanPowerUp, outputUpdated, ampPowered;
    logic [7:0] diffPair;
    range_e [15:0] rangeSel;
    code_t [15:0] dacCode;
    int n_mismatch = 0;
    int checks = 0;

    always #50 clk = ~clk;
    always #24 linkClk = ~linkClk;

    dac_update_control #(.RES(16)) i_dut (.clk(clk), .rst_n(rst_n), .linkClk(linkClk),
        .frameEnd(frameEnd), .frameKind(frameKind), .frameChan(frameChan),
        .frameData(frameData), .frameReady(frameReady), .loadTriggerPin_n(loadTriggerPin_n),
        .clearOutputsPin_n(clearOutputsPin_n), .syncEnable(syncEnable),
        .channelBroadcastJoin(channelBroadcastJoin), .diffPair(diffPair),
        .rangeSel(rangeSel), .toggleEnable(toggleEnable), .toggleSelect(toggleSelect),
        .chanPowerUp(chanPowerUp), .dacCode(dacCode), .outputUpdated(outputUpdated),
        .ampPowered(ampPowered));

    host_link_model i_host (.linkClk(linkClk), .frameReady(frameReady), .frameEnd(frameEnd),
        .frameKind(frameKind), .frameChan(frameChan), .frameData(frameData));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : settle

    // waitCh < 0: no update expected, just the spacing
    task automatic frame(input frame_e k, input logic [3:0] c, input code_t d, input int waitCh);
        bit ok;
        i_host.send(k, c, d, ok);
        if (!ok) begin
            n_mismatch++;
            complete_run();
        end
        for (int n = 0; waitCh >= 0 && outputUpdated[waitCh] !== 1'b1; n++) begin
            if (n == 80) begin
                n_mismatch++;
                complete_run();
            end
            @(negedge clk);
        end
        // the update pulse stands for one clock only
        if (waitCh >= 0) begin
            @(negedge clk);
            check(outputUpdated, 16'h0000);
        end
        settle(45);
    endtask : frame

    task automatic load_pin();
        @(posedge clk);
        loadTriggerPin_n <= 1'b0;
        repeat (2) @(posedge clk);
        loadTriggerPin_n <= 1'b1;
        settle(45);
    endtask : load_pin

    function automatic code_t clear_code_exp(input int ch);
        return (rangeSel[ch][2] || diffPair[ch / 2]) ? MID : 16'h0000;
    endfunction : clear_code_exp

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        loadTriggerPin_n = 1'b1;
        clearOutputsPin_n = 1'b1;
        syncEnable = 16'h0000;
        channelBroadcastJoin = 16'h0000;
        diffPair = 8'h00;
        rangeSel = '{default: RANGE_U5};
        toggleEnable = 16'h0000;
        toggleSelect = 16'h0000;
        chanPowerUp = 16'h0000;
        settle(12);
        for (int c = 0; c < 16; c++) check(dacCode[c], 16'h0000);
        check(ampPowered, 16'h0000);
        @(posedge clk);
        rst_n <= 1'b1;
        settle(10000);
        @(posedge clk);
        chanPowerUp <= 16'hFFDF;
        settle(3);
        check(ampPowered, 16'hFFDF);
        frame(KIND_DATA, 4'h5, 16'h1234, 5);
        check(dacCode[5], 16'h1234);
        frame(KIND_DATA, 4'h3, 16'hFFFF, 3);
        check(dacCode[3], 16'hFFFF);
        @(posedge clk);
        chanPowerUp <= 16'hFFD7;
        settle(3);
        check(ampPowered, 16'hFFD7);
        check(dacCode[3], 16'hFFFF);
        @(posedge clk);
        syncEnable <= 16'h0030;
        frame(KIND_DATA, 4'h4, 16'hA5A5, -1);
        check(dacCode[4], 16'h0000);
        frame(KIND_TRIGGER, 4'h0, 16'h0000, 4);
        check(dacCode[4], 16'hA5A5);
        check(dacCode[5], 16'h1234);
        frame(KIND_DATA, 4'h4, 16'h5A5A, -1);
        frame(KIND_DATA, 4'h5, 16'h0F0F, -1);
        check(dacCode[4], 16'hA5A5);
        load_pin();
        check(dacCode[4], 16'h5A5A);
        check(dacCode[5], 16'h0F0F);
        @(posedge clk);
        channelBroadcastJoin <= 16'h00E0;
        frame(KIND_BCAST, 4'h0, 16'h3C3C, 6);
        check(dacCode[6], 16'h3C3C);
        check(dacCode[3], 16'hFFFF);
        check(dacCode[5], 16'h0F0F);
        load_pin();
        check(dacCode[5], 16'h3C3C);
        check(dacCode[4], 16'h5A5A);
        @(posedge clk);
        diffPair <= 8'h01;
        frame(KIND_BCAST, 4'h0, 16'h7777, -1);
        check(dacCode[7], 16'h3C3C);
        @(posedge clk);
        rangeSel[4] <= RANGE_B10;
        toggleEnable <= 16'h0040;
        toggleSelect <= 16'h0040;
        frame(KIND_ALT, 4'h6, 16'h1111, -1);
        // both pins pulse low in one clock: clear must win
        @(posedge clk);
        clearOutputsPin_n <= 1'b0;
        loadTriggerPin_n <= 1'b0;
        @(posedge clk);
        clearOutputsPin_n <= 1'b1;
        loadTriggerPin_n <= 1'b1;
        settle(8);
        for (int c = 0; c < 16; c++) check(dacCode[c], clear_code_exp(c));
        @(posedge clk);
        toggleSelect <= 16'h0000;
        settle(45);
        check(dacCode[6], 16'h0000);
        check(dacCode[4], MID);
        // second reset in mid-run, then the link must work again
        @(posedge clk);
        rst_n <= 1'b0;
        settle(4);
        for (int c = 0; c < 16; c++) check(dacCode[c], 16'h0000);
        check(ampPowered, 16'h0000);
        @(posedge clk);
        rst_n <= 1'b1;
        settle(10000);
        frame(KIND_DATA, 4'h2, 16'h0ABC, 2);
        check(dacCode[2], 16'h0ABC);
        complete_run();
    end
endmodule : multichannel_dac_update_control_tb

`default_nettype wire
